//--- rtl/gex_consts.svh
// Constants for the guest event exit control block
`ifndef GEX_CONSTS_SVH
`define GEX_CONSTS_SVH
`define GEX_VEC_DF 5'h08
`define GEX_VEC_PF 5'h0e
`define GEX_VEC_BR 5'h05
`define GEX_VEC_OF 5'h04
`define GEX_VEC_BP 5'h03
`define GEX_RSN_EXC 16'h0000
`define GEX_RSN_EXT 16'h0001
`define GEX_RSN_TRIPLE 16'h0002
`define GEX_RSN_INIT 16'h0003
`define GEX_RSN_STARTUP_IPI_EVENT 16'h0004
`define GEX_RSN_NMI 16'h0000
`define GEX_BLK_STI 0
`define GEX_BLK_SS 1
`define GEX_BLK_SMI 2
`define GEX_BLK_NMI 3
`define GEX_INFO_VALID 31
`define GEX_ACK_TIMEOUT_NS 4000
`define GEX_CLK_NS 40
`define GEX_ACK_TIMEOUT_CYC (`GEX_ACK_TIMEOUT_NS / `GEX_CLK_NS)
`endif

//--- rtl/gex_event_exit.sv
// Guest event exit decision, acknowledge and blocking-state tracking
`timescale 1ns/1ps
`include "gex_consts.svh"

module gex_event_exit (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire gex_pkg::gex_ctrl_t ctrl,
    input wire logic guest_entry,
    input wire logic [3:0] entry_blocking,
    input wire gex_pkg::gex_exc_t exc,
    input wire logic in_df_delivery,
    input wire logic ext_irq,
    input wire logic nmi_evt,
    input wire logic init_evt,
    input wire logic startup_ipi_event,
    input wire logic smm_active,
    input wire logic set_interrupt_flag_instr,
    input wire logic stack_segment_move_instr,
    input wire logic instr_retire,
    input wire logic system_mgmt_interrupt,
    input wire logic resume_from_mgmt_instr,
    input wire logic interrupt_return_instr,
    input wire logic host_if_set,
    input wire logic ack_done,
    input wire logic [7:0] ack_vector,
    output gex_pkg::gex_exit_t exit_out,
    output logic [3:0] exit_blocking,
    output logic in_guest,
    output logic interrupt_enable_flag,
    output logic deliver_guest,
    output logic [4:0] deliver_vector,
    output logic deliver_ext,
    output logic ack_req,
    output logic host_ack_req,
    output logic init_blocked,
    output logic vnmi_ready
);
    import gex_pkg::*;

    // ==========================================================
    // Decode
    gex_state_t state;
    gex_state_t next_state;
    logic [3:0] blocking;
    logic vnmi_blocked;
    logic pend_host_irq;
    logic [7:0] ack_cnt;
    logic guest_if;

    // Mask lookup by vector number
    function automatic logic mask_bit(input logic [31:0] m, input logic [4:0] v);
        return m[v];
    endfunction

    wire guest_run = (state == GEX_GUEST);
    wire ext_blocked = blocking[`GEX_BLK_STI] | blocking[`GEX_BLK_SS];
    wire nmi_block = blocking[`GEX_BLK_NMI] | blocking[`GEX_BLK_SS];
    wire pf_hit = ((exc.error_code & ctrl.pf_ec_mask) == ctrl.pf_ec_match);
    wire exc_sel = mask_bit(ctrl.exc_mask, exc.vector);
    // exception exit selection, covers instr traps too
    wire exc_exit_raw = (exc.vector == `GEX_VEC_PF) ? (exc_sel == pf_hit) : exc_sel;
    wire exc_exit = guest_run & exc.valid & exc_exit_raw;
    wire triple = guest_run & exc.valid & ~exc_exit_raw & in_df_delivery;
    // guest delivery through guest vector table
    wire exc_guest = guest_run & exc.valid & ~exc_exit_raw & ~in_df_delivery;
    wire ext_exit = guest_run & ext_irq & ctrl.ext_exit;
    wire ext_guest = guest_run & ext_irq & ~ctrl.ext_exit & guest_if & ~ext_blocked;
    // non-maskable pin control, virtual tracking forces exit
    wire nmi_exit = guest_run & nmi_evt & (ctrl.nmi_exit | ctrl.virt_nmi);
    wire init_exit = guest_run & init_evt;
    wire startup_ipi_event_exit = guest_run & startup_ipi_event;
    wire any_exit = exc_exit | triple | ext_exit | nmi_exit | init_exit | startup_ipi_event_exit;
    wire [15:0] reason = init_exit ? `GEX_RSN_INIT :
                         startup_ipi_event_exit ? `GEX_RSN_STARTUP_IPI_EVENT :
                         triple ? `GEX_RSN_TRIPLE :
                         nmi_exit ? `GEX_RSN_NMI :
                         exc_exit ? `GEX_RSN_EXC : `GEX_RSN_EXT;
    wire is_ext = ext_exit & ~init_exit & ~startup_ipi_event_exit & ~triple & ~nmi_exit & ~exc_exit;
    wire ack_timeout = (ack_cnt == 8'(`GEX_ACK_TIMEOUT_CYC));

    // Handshake outputs
    assign ack_req = (state == GEX_ACK);
    assign host_ack_req = (state == GEX_ROOT) & pend_host_irq & interrupt_enable_flag;
    assign init_blocked = (state != GEX_GUEST) | smm_active;
    assign in_guest = guest_run;
    assign exit_blocking = blocking;
    assign vnmi_ready = ctrl.virt_nmi & ~vnmi_blocked;

    // ==========================================================
    // State machine
    always_comb begin
        next_state = state;
        unique case (state)
            GEX_ROOT: begin
                if (guest_entry) begin
                    next_state = GEX_GUEST;
                end
            end
            GEX_GUEST: begin
                // acknowledge path, skip it when clear
                if (any_exit && is_ext && ctrl.ack_on_exit) begin
                    next_state = GEX_ACK;
                end else if (any_exit) begin
                    next_state = GEX_ROOT;
                end
            end
            GEX_ACK: begin
                if (ack_done || ack_timeout) begin
                    next_state = GEX_ROOT;
                end
            end
            default: next_state = GEX_ROOT;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= GEX_ROOT;
        end else begin
            state <= next_state;
        end
    end

    // Acknowledge wait counter
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_cnt <= 8'h00;
        end else if (state == GEX_ACK) begin
            ack_cnt <= ack_cnt + 8'h01;
        end else begin
            ack_cnt <= 8'h00;
        end
    end

    // ==========================================================
    // Exit record
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            exit_out <= '0;
        end else if (state == GEX_GUEST && any_exit) begin
            exit_out.valid <= ~(is_ext & ctrl.ack_on_exit);
            exit_out.reason <= reason;
            exit_out.info <= (exc_exit & ~is_ext) ?
                {1'b1, 26'h0, exc.vector} : 32'h0;
        end else if (state == GEX_ACK && (ack_done || ack_timeout)) begin
            exit_out.valid <= 1'b1;
            exit_out.info <= ack_done ? {1'b1, 23'h0, ack_vector} : 32'h0;
        end else begin
            exit_out.valid <= 1'b0;
        end
    end

    // Guest delivery outputs
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            deliver_guest <= 1'b0;
            deliver_vector <= 5'h00;
            deliver_ext <= 1'b0;
        end else begin
            deliver_guest <= exc_guest & ~any_exit;
            deliver_vector <= exc.vector;
            deliver_ext <= ext_guest & ~any_exit;
        end
    end

    // ==========================================================
    // Interrupt enable flags
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            guest_if <= 1'b0;
            interrupt_enable_flag <= 1'b0;
            pend_host_irq <= 1'b0;
        end else begin
            if (set_interrupt_flag_instr && guest_run) begin
                guest_if <= 1'b1;
            end
            if (state == GEX_GUEST && any_exit && is_ext) begin
                interrupt_enable_flag <= 1'b0;
                pend_host_irq <= ~ctrl.ack_on_exit;
            end else if (host_if_set) begin
                interrupt_enable_flag <= 1'b1;
            end
            if (host_ack_req) begin
                pend_host_irq <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Blocking state
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            blocking <= 4'h0;
        end else if (state == GEX_ROOT && guest_entry) begin
            blocking <= entry_blocking;
        end else if (guest_run) begin
            if (set_interrupt_flag_instr) begin
                blocking[`GEX_BLK_STI] <= 1'b1;
            end else if (instr_retire) begin
                blocking[`GEX_BLK_STI] <= 1'b0;
            end
            if (stack_segment_move_instr) begin
                blocking[`GEX_BLK_SS] <= 1'b1;
            end else if (instr_retire) begin
                blocking[`GEX_BLK_SS] <= 1'b0;
            end
            if (system_mgmt_interrupt) begin
                blocking[`GEX_BLK_SMI] <= 1'b1;
            end else if (resume_from_mgmt_instr) begin
                blocking[`GEX_BLK_SMI] <= 1'b0;
            end
            if (nmi_evt || system_mgmt_interrupt) begin
                blocking[`GEX_BLK_NMI] <= 1'b1;
            end else if (interrupt_return_instr || resume_from_mgmt_instr) begin
                blocking[`GEX_BLK_NMI] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vnmi_blocked <= 1'b0;
        end else if (state == GEX_ROOT && guest_entry) begin
            vnmi_blocked <= entry_blocking[`GEX_BLK_NMI];
        end else if (guest_run && interrupt_return_instr) begin
            vnmi_blocked <= 1'b0;
        end else if (guest_run && nmi_block) begin
            vnmi_blocked <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    property p_ext_reason;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == GEX_GUEST && is_ext && any_exit && !ctrl.ack_on_exit) |=>
            exit_out.valid && exit_out.reason == 16'h0001;
    endproperty
    a_ext_reason: assert property (p_ext_reason) else $error("bad ext reason");

    property p_init_exit;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == GEX_GUEST && init_evt) |=> state != GEX_GUEST;
    endproperty
    a_init_exit: assert property (p_init_exit) else $error("init no exit");

    property p_ack_store;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == GEX_ACK && ack_done) |=> exit_out.valid && exit_out.info[7:0] == $past(ack_vector);
    endproperty
    a_ack_store: assert property (p_ack_store) else $error("ack vector lost");

    property p_no_ack;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == GEX_GUEST && any_exit && !ctrl.ack_on_exit) |=> !ack_req;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("unwanted ack");

    property p_if_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == GEX_GUEST && any_exit && is_ext) |=> !interrupt_enable_flag;
    endproperty
    a_if_clear: assert property (p_if_clear) else $error("flag not cleared");

    property p_entry_load;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == GEX_ROOT && guest_entry) |=> exit_blocking == $past(entry_blocking);
    endproperty
    a_entry_load: assert property (p_entry_load) else $error("blocking not loaded");

    property p_init_blk;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == GEX_ROOT || smm_active) |-> init_blocked;
    endproperty
    a_init_blk: assert property (p_init_blk) else $error("init not blocked");

    property p_ext_guest;
        @(posedge sys_clk) disable iff (!rst_b)
        (state == GEX_GUEST && ext_irq && !ctrl.ext_exit && !guest_if) |=> !deliver_ext;
    endproperty
    a_ext_guest: assert property (p_ext_guest) else $error("ext delivered masked");

    property p_exc_guest;
        @(posedge sys_clk) disable iff (!rst_b)
        (exc_guest && !any_exit) |=> deliver_guest && deliver_vector == $past(exc.vector);
    endproperty
    a_exc_guest: assert property (p_exc_guest) else $error("exc not delivered");
endmodule

//--- rtl/gex_pkg.sv
// Types for the guest event exit control block
package gex_pkg;
    typedef enum logic [1:0] {
        GEX_ROOT = 2'b00,
        GEX_GUEST = 2'b01,
        GEX_ACK = 2'b10
    } gex_state_t;

    typedef struct packed {
        logic [31:0] exc_mask;
        logic [31:0] pf_ec_mask;
        logic [31:0] pf_ec_match;
        logic ext_exit;
        logic nmi_exit;
        logic virt_nmi;
        logic ack_on_exit;
    } gex_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [4:0] vector;
        logic [31:0] error_code;
    } gex_exc_t;

    typedef struct packed {
        logic valid;
        logic [15:0] reason;
        logic [31:0] info;
    } gex_exit_t;
endpackage

//--- tb/gex_irq_model.sv
// Interrupt controller model that answers acknowledge cycles
`timescale 1ns/1ps
module gex_irq_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ack_req,
    input wire logic [7:0] delay_cyc,
    input wire logic [7:0] vec_in,
    output logic ack_done,
    output logic [7:0] ack_vector
);
    logic [7:0] cnt;
    // vector return
    // Answer delay_cyc+1 cycles after ack_req is seen; vector churns while ack_req is low
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 8'h00;
            ack_done <= 1'b0;
            ack_vector <= 8'h00;
        end else if (ack_done || !ack_req) begin
            cnt <= 8'h00;
            ack_done <= 1'b0;
            ack_vector <= ~ack_vector;
        end else if (cnt == delay_cyc) begin
            ack_done <= 1'b1;
            ack_vector <= vec_in;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the guest event exit control block
`timescale 1ns/1ps
`include "gex_consts.svh"
module testbench;
    import gex_pkg::*;
    logic sys_clk, rst_b, guest_entry, in_df_delivery, smm_active, instr_retire;
    logic ext_irq, nmi_evt, init_evt, startup_ipi_event, host_if_set, ack_done;
    logic in_guest, interrupt_enable_flag, deliver_guest, deliver_ext, ack_req;
    logic host_ack_req, init_blocked, vnmi_ready;
    logic [3:0] entry_blocking, exit_blocking;
    logic [4:0] blk_ev, deliver_vector;
    logic [7:0] ack_vector, delay_cyc, vec_in;
    gex_ctrl_t ctrl;
    gex_exc_t exc;
    gex_exit_t exit_out;
    int fails = 0, check_count = 0, exit_seen = 0, ack_seen = 0, i, n;
    logic [4:0] vlist [6] = '{5'h00, `GEX_VEC_BP, `GEX_VEC_OF, `GEX_VEC_BR, 5'h11, 5'h1f};
    logic [3:0] b_in [4] = '{4'b1010, 4'b0000, 4'b1100, 4'b1000};
    logic [4:0] b_ev [4] = '{5'b00000, 5'b00111, 5'b01000, 5'b10000};
    logic [3:0] b_out [4] = '{4'b1010, 4'b1111, 4'b0000, 4'b0000};

    gex_event_exit gex_event_exit_inst (.sys_clk(sys_clk), .rst_b(rst_b), .ctrl(ctrl),
        .guest_entry(guest_entry), .entry_blocking(entry_blocking), .exc(exc),
        .in_df_delivery(in_df_delivery), .ext_irq(ext_irq), .nmi_evt(nmi_evt),
        .init_evt(init_evt), .startup_ipi_event(startup_ipi_event),
        .smm_active(smm_active), .set_interrupt_flag_instr(blk_ev[0]),
        .stack_segment_move_instr(blk_ev[1]), .instr_retire(instr_retire),
        .system_mgmt_interrupt(blk_ev[2]), .resume_from_mgmt_instr(blk_ev[3]),
        .interrupt_return_instr(blk_ev[4]), .host_if_set(host_if_set),
        .ack_done(ack_done), .ack_vector(ack_vector), .exit_out(exit_out),
        .exit_blocking(exit_blocking), .in_guest(in_guest),
        .interrupt_enable_flag(interrupt_enable_flag), .deliver_guest(deliver_guest),
        .deliver_vector(deliver_vector), .deliver_ext(deliver_ext), .ack_req(ack_req),
        .host_ack_req(host_ack_req), .init_blocked(init_blocked), .vnmi_ready(vnmi_ready));

    gex_irq_model gex_irq_model_inst (.sys_clk(sys_clk), .rst_b(rst_b), .ack_req(ack_req),
        .delay_cyc(delay_cyc), .vec_in(vec_in), .ack_done(ack_done), .ack_vector(ack_vector));

    // Clock, 40 ns period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Count exit pulses and acknowledge cycles
    always @(negedge sys_clk) begin
        if (exit_out.valid === 1'b1) exit_seen++;
        if (ack_req === 1'b1) ack_seen++;
    end

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic cmp_vec(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic enter(input logic [3:0] blk);
        @(negedge sys_clk);
        guest_entry = 1'b1;
        entry_blocking = blk;
        @(negedge sys_clk);
        guest_entry = 1'b0;
        @(negedge sys_clk);
    endtask

    // Pulses {ext, nmi, init, startup} and blocking events for one cycle
    task automatic fire(input logic [3:0] ev, input logic [4:0] bev);
        {ext_irq, nmi_evt, init_evt, startup_ipi_event} = ev;
        blk_ev = bev;
        @(negedge sys_clk);
        {ext_irq, nmi_evt, init_evt, startup_ipi_event} = 4'h0;
        blk_ev = 5'h00;
    endtask

    task automatic raise(input logic [4:0] v, input logic [31:0] ec);
        exc = '{1'b1, v, ec};
        @(negedge sys_clk);
        exc.valid = 1'b0;
    endtask

    task automatic exp_exit(input logic [15:0] rsn);
        for (n = 0; n < 150 && exit_out.valid !== 1'b1; n++) @(negedge sys_clk);
        cmp_bit("exit valid", 1'b1, exit_out.valid);
        cmp_vec("exit reason", {16'h0000, rsn}, {16'h0000, exit_out.reason});
        @(negedge sys_clk);
        cmp_bit("in guest after exit", 1'b0, in_guest);
    endtask

    task automatic no_exit();
        int k;
        k = exit_seen;
        repeat (5) @(negedge sys_clk);
        cmp_vec("exit count", k, exit_seen);
        fire(4'b0010, 5'h00);
        exp_exit(`GEX_RSN_INIT);
    endtask

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #(40 * 20000);
        fails++;
        stop_test();
    end

    initial begin
        rst_b = 1'b0; guest_entry = 1'b0; entry_blocking = 4'h0; exc = '0;
        in_df_delivery = 1'b0; smm_active = 1'b0; instr_retire = 1'b0; blk_ev = 5'h00;
        {ext_irq, nmi_evt, init_evt, startup_ipi_event} = 4'h0; host_if_set = 1'b0;
        delay_cyc = 8'h03; vec_in = 8'h41; ctrl = '0;
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        cmp_bit("init blocked root", 1'b1, init_blocked);
        enter(4'h0);
        cmp_bit("init blocked guest", 1'b0, init_blocked);
        smm_active = 1'b1;
        #1 cmp_bit("init blocked smm", 1'b1, init_blocked);
        smm_active = 1'b0;
        fire(4'b0011, 5'h00);
        exp_exit(`GEX_RSN_INIT);
        enter(4'h0);
        fire(4'b0001, 5'h00);
        exp_exit(`GEX_RSN_STARTUP_IPI_EVENT);
        for (i = 0; i < 6; i++) begin
            ctrl.exc_mask = 32'h1 << vlist[i];
            enter(4'h0);
            raise(vlist[i], 32'h0);
            exp_exit(`GEX_RSN_EXC);
            cmp_vec("exit vector", {27'h0, vlist[i]}, {27'h0, exit_out.info[4:0]});
            ctrl.exc_mask = ~(32'h1 << vlist[i]);
            enter(4'h0);
            raise(vlist[i], 32'h0);
            for (n = 0; n < 10 && deliver_guest !== 1'b1; n++) @(negedge sys_clk);
            cmp_bit("deliver guest", 1'b1, deliver_guest);
            cmp_vec("deliver vector", {27'h0, vlist[i]}, {27'h0, deliver_vector});
            no_exit();
        end
        ctrl = '0;
        ctrl.exc_mask = 32'h1 << `GEX_VEC_PF;
        ctrl.pf_ec_mask = 32'h0000_0003;
        ctrl.pf_ec_match = 32'h0000_0001;
        enter(4'h0);
        raise(`GEX_VEC_PF, 32'h0000_0005);
        exp_exit(`GEX_RSN_EXC);
        enter(4'h0);
        raise(`GEX_VEC_PF, 32'h0000_0002);
        no_exit();
        ctrl.exc_mask = 32'h0;
        in_df_delivery = 1'b1;
        enter(4'h0);
        raise(5'h0d, 32'h0);
        exp_exit(`GEX_RSN_TRIPLE);
        in_df_delivery = 1'b0;
        ctrl.nmi_exit = 1'b1;
        enter(4'h0);
        fire(4'b0100, 5'h00);
        exp_exit(`GEX_RSN_NMI);
        ctrl.nmi_exit = 1'b0;
        enter(4'h0);
        fire(4'b0100, 5'h00);
        no_exit();
        ctrl.virt_nmi = 1'b1;
        enter(4'h8);
        cmp_bit("vnmi ready blocked", 1'b0, vnmi_ready);
        fire(4'h0, 5'h10);
        cmp_bit("vnmi ready after return", 1'b1, vnmi_ready);
        fire(4'b0100, 5'h00);
        exp_exit(`GEX_RSN_NMI);
        ctrl.virt_nmi = 1'b0;
        enter(4'h0);
        fire(4'b1000, 5'h00);
        no_exit();
        enter(4'h0);
        fire(4'h0, 5'h01);
        instr_retire = 1'b1;
        @(negedge sys_clk);
        instr_retire = 1'b0;
        fire(4'b1000, 5'h00);
        cmp_bit("deliver ext", 1'b1, deliver_ext);
        no_exit();
        ctrl.ext_exit = 1'b1;
        ctrl.ack_on_exit = 1'b1;
        enter(4'h0);
        fire(4'b1000, 5'h00);
        exp_exit(`GEX_RSN_EXT);
        cmp_vec("exit info", 32'h8000_0041, exit_out.info);
        cmp_bit("enable flag", 1'b0, interrupt_enable_flag);
        delay_cyc = 8'hff;
        enter(4'h0);
        fire(4'b1000, 5'h00);
        exp_exit(`GEX_RSN_EXT);
        cmp_vec("timeout info", 32'h0, exit_out.info);
        ctrl.ack_on_exit = 1'b0;
        i = ack_seen;
        enter(4'h0);
        fire(4'b1000, 5'h00);
        exp_exit(`GEX_RSN_EXT);
        cmp_vec("ack cycles", i, ack_seen);
        host_if_set = 1'b1;
        #5 n = host_ack_req;
        @(negedge sys_clk);
        host_if_set = 1'b0;
        #5 cmp_bit("host ack", 1'b1, n | host_ack_req);
        cmp_bit("enable flag set", 1'b1, interrupt_enable_flag);
        ctrl = '0;
        for (i = 0; i < 4; i++) begin
            enter(b_in[i]);
            fire(4'h0, b_ev[i]);
            fire(4'b0010, 5'h00);
            exp_exit(`GEX_RSN_INIT);
            cmp_vec("blocking", {28'h0, b_out[i]}, {28'h0, exit_blocking});
        end
        stop_test();
    end
endmodule
